/* include/pps_pkg.sv */
package pps_pkg;
	// ==============================================================
	// Clock and timing
	// ==============================================================
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned SCAN_HZ = 10_000;
	localparam int unsigned SCAN_DIV_CYC = CLK_HZ / SCAN_HZ;
	localparam int unsigned ONLINE_HZ = 30;
	// Least hold time: round up so a 30 Hz poll rate still keeps it lit
	localparam int unsigned ONLINE_CYC = (CLK_HZ + ONLINE_HZ - 1) / ONLINE_HZ;
	localparam int unsigned LATCH_DLY_NS = 50;
	localparam int unsigned LATCH_DLY_CYC = (LATCH_DLY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned ADC_PULSE_NS = 100;
	localparam int unsigned ADC_PULSE_CYC = (ADC_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Contact detector timeout in scan steps; must exceed one 32-step sweep
	localparam int unsigned DET_STEPS = 48;

	// ==============================================================
	// Scan positions
	// ==============================================================
	localparam int unsigned POS_W = 5;
	localparam int unsigned NUM_JACKS = 28;
	localparam int unsigned FIRST_TP = 3;
	localparam logic [4:0] POS_OPEN = 5'h00;
	localparam logic [4:0] POS_GROUND = 5'h01;
	localparam logic [4:0] POS_SHORT = 5'h02;
	localparam logic [4:0] POS_WRAP = 5'h1F;

	// ==============================================================
	// Readout words
	// ==============================================================
	localparam int unsigned WORD_W = 12;
	localparam logic [1:0] SEL_PROBES = 2'h0;
	localparam logic [1:0] SEL_OHMS = 2'h1;
	localparam logic [1:0] SEL_SWITCH = 2'h2;

	// ==============================================================
	// Register map (byte offsets)
	// ==============================================================
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WORD = 8'h08;
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
endpackage

/* rtl/pps_retrig.sv */
// Retriggerable one-shot: reloads on trig, counts down on step.
module pps_retrig #(
	parameter int unsigned W = 24,
	parameter int unsigned LEN = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic trig,
	input wire logic step,
	output logic active
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
		end else if (trig) begin
			cnt_r <= W'(LEN);
		end else if (step && cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	assign active = (cnt_r != '0);
endmodule // pps_retrig

/* rtl/pps_scanner.sv */
// What this block does
// - Free-running 10 kHz scan tick steps a five-bit counter over 32 positions.
// - Positions 3..30 drive 28 jacks; three codes reserved, one unused.
// - Each jack pulses low while the counter equals its number.
// - Per-probe retriggerable contact detector; received pulse strobes count into latch.
// - Latch strobe is delayed after the scan step so the count is stable.
// - Each probe latch keeps a five-bit position number.
// - Touching probe is recaptured every sweep, about 300 Hz.
// - Black probe has identical detector, gating and latch; scan shared.
// - Reserved codes: 0 open, 1 grounded, 2 probes shorted together.
// - Detector timed out: count zero strobes zero into the latch.
// - Ground input asserted: count zero loads one instead of zero.
// - Short input asserted: red zero strobe loads two into both latches.
// - Poll strobe active halts the scan so positions cannot change.
// - Poll strobe trailing edge issues an ADC start-conversion pulse.
// - Retriggerable poll timer holds on-line lit for polls 30 Hz or faster.
// - Four-word twelve-bit readout mux, three used, chosen by two selects.
// - Selects low,high: 00 probes, 10 ohms adjust, 01 switch positions.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
module pps_scanner #(
	parameter int unsigned SCAN_DIV = pps_pkg::SCAN_DIV_CYC,
	parameter int unsigned ONLINE_LEN = pps_pkg::ONLINE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Test jacks and probes
	output logic [27:0] test_point_n,
	input wire logic red_probe_n,
	input wire logic blk_probe_n,
	input wire logic red_ground,
	input wire logic blk_ground,
	input wire logic probes_shorted,
	// Host poll side
	input wire logic poll_strobe,
	input wire logic word_select_low,
	input wire logic word_select_high,
	output logic [11:0] host_word,
	output logic online,
	output logic adc_start,
	// Panel inputs
	input wire logic [7:0] adc_result,
	input wire logic [2:0] function_sw,
	input wire logic [2:0] range_sw,
	input wire logic [3:0] board_id,
	input wire logic power_sw
);
	// ==============================================================
	// Declarations
	// ==============================================================
	logic [31:0] ctrl_r;
	logic [15:0] div_r;
	logic scan_tick;
	logic scan_halt;
	logic [4:0] count_r;
	logic [7:0] dly_r;
	logic latch_stb;
	logic poll_d_r;
	logic poll_fall;
	logic poll_rise;
	logic [1:0] probe_n;
	logic [1:0] ground;
	logic [1:0] det_active;
	logic [1:0] det_trig;
	logic [4:0] pos_r [2];
	logic [1:0] word_sel;
	logic [11:0] word_nxt;
	logic addr_sel_r;
	logic addr_wr_r;
	logic [7:0] addr_r;
	logic [31:0] rdata_nxt;
	logic [27:0] jack_n_nxt;
	logic [11:0] probes_word;
	logic [11:0] ohms_word;
	logic [11:0] switch_word;
	logic [31:0] status_word;
	logic wr_ctrl;
	logic rd_sel;

	// ==============================================================
	// Scan oscillator and counter
	// ==============================================================
	// Halting the divider too keeps the phase of the interrupted step
	assign scan_halt = poll_strobe || !ctrl_r[pps_pkg::CTRL_RUN_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= '0;
		end else if (!scan_halt) begin
			if (div_r == 16'(SCAN_DIV - 1)) begin
				div_r <= '0;
			end else begin
				div_r <= div_r + 16'h0001;
			end
		end
	end

	// SCAN_DIV must exceed the latch delay, or the strobe is reloaded before it fires
	assign scan_tick = !scan_halt && (div_r == 16'(SCAN_DIV - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= pps_pkg::POS_OPEN;
		end else if (scan_tick) begin
			if (count_r == pps_pkg::POS_WRAP) begin
				count_r <= pps_pkg::POS_OPEN;
			end else begin
				count_r <= count_r + 5'h01;
			end
		end
	end

	// ==============================================================
	// Jack drive
	// ==============================================================
	// Decoding the counter straight onto the pins would let a jack glitch
	// low while the count bits settle; the register gives clean pulses
	// Jacks lag the count by one cycle, well inside the latch delay
	generate
		for (genvar j = 0; j < 28; j++) begin : g_jack
			assign jack_n_nxt[j] =
				(count_r != 5'(j + pps_pkg::FIRST_TP));
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_point_n <= '1;
		end else begin
			test_point_n <= jack_n_nxt;
		end
	end

	// ==============================================================
	// Delayed latch strobe
	// ==============================================================
	// The strobe fires well after the counter step, never on it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dly_r <= '0;
		end else if (scan_tick) begin
			dly_r <= 8'(pps_pkg::LATCH_DLY_CYC);
		end else if (dly_r != '0) begin
			dly_r <= dly_r - 8'h01;
		end
	end

	// A poll in progress suppresses capture as well as the scan
	assign latch_stb = (dly_r == 8'h01) && !poll_strobe;

	// ==============================================================
	// Probe detectors and position latches
	// ==============================================================
	assign probe_n = {blk_probe_n, red_probe_n};
	assign ground = {blk_ground, red_ground};

	generate
		for (genvar p = 0; p < 2; p++) begin : g_probe
			logic [4:0] zero_pos;
			logic zero_load;
			// Shares scan, counter and strobe; only this part repeats
			assign det_trig[p] = latch_stb && !probe_n[p];

			pps_retrig #(
				.W(8),
				.LEN(pps_pkg::DET_STEPS)
			) u_det (
				.hclk(hclk),
				.hresetn(hresetn),
				.trig(det_trig[p]),
				.step(scan_tick),
				.active(det_active[p])
			);

			// Value a count-zero strobe loads while this probe is idle;
			// a short outranks ground, and ground outranks open
			always_comb begin
				if (probes_shorted && !det_active[0]) begin
					zero_pos = pps_pkg::POS_SHORT;
				end else if (ground[p]) begin
					zero_pos = pps_pkg::POS_GROUND;
				end else begin
					zero_pos = pps_pkg::POS_OPEN;
				end
			end

			// The short case borrows the red strobe even if black still counts down
			assign zero_load = latch_stb && (count_r == pps_pkg::POS_OPEN)
				&& ((probes_shorted && !det_active[0]) || !det_active[p]);

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pos_r[p] <= pps_pkg::POS_OPEN;
				end else if (det_trig[p]) begin
					pos_r[p] <= count_r;
				end else if (zero_load) begin
					pos_r[p] <= zero_pos;
				end
			end
		end
	endgenerate

	// ==============================================================
	// Poll strobe: ADC start and on-line timer
	// ==============================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			poll_d_r <= 1'b0;
		end else begin
			poll_d_r <= poll_strobe;
		end
	end

	assign poll_fall = poll_d_r && !poll_strobe;
	assign poll_rise = !poll_d_r && poll_strobe;

	// Starting only after the read lets the host take the old result first
	pps_retrig #(
		.W(8),
		.LEN(pps_pkg::ADC_PULSE_CYC)
	) u_adc (
		.hclk(hclk),
		.hresetn(hresetn),
		.trig(poll_fall),
		.step(1'b1),
		.active(adc_start)
	);

	pps_retrig #(
		.W(24),
		.LEN(ONLINE_LEN)
	) u_online (
		.hclk(hclk),
		.hresetn(hresetn),
		.trig(poll_rise),
		.step(1'b1),
		.active(online)
	);

	// ==============================================================
	// Readout multiplexer
	// ==============================================================
	assign word_sel = {word_select_high, word_select_low};

	// Red sits above black; the low bits of the ohms word stay zero
	assign probes_word = {2'h0, pos_r[0], pos_r[1]};
	assign ohms_word = {adc_result, 4'h0};
	assign switch_word = {function_sw, range_sw, board_id, power_sw, 1'b0};

	always_comb begin
		case (word_sel)
			pps_pkg::SEL_PROBES: begin
				word_nxt = probes_word;
			end
			pps_pkg::SEL_OHMS: begin
				word_nxt = ohms_word;
			end
			pps_pkg::SEL_SWITCH: begin
				word_nxt = switch_word;
			end
			default: begin
				word_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			host_word <= '0;
		end else begin
			host_word <= word_nxt;
		end
	end

	// ==============================================================
	// AHB-Lite register slave
	// ==============================================================
	// Zero wait states: every transfer completes in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Read data is fetched in the address phase so it stands through the data phase
	assign rd_sel = hready && hsel && htrans[1] && !hwrite;
	// A write lands at the end of its data phase, while hwdata stands
	assign wr_ctrl = addr_sel_r && addr_wr_r && hready && (addr_r == pps_pkg::REG_CTRL);
	// Count and both positions stay readable between captures
	assign status_word = {11'h0, online, det_active, pos_r[1], pos_r[0],
		3'h0, count_r};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_sel_r <= 1'b0;
			addr_wr_r <= 1'b0;
			addr_r <= '0;
		end else if (hready) begin
			addr_sel_r <= hsel && htrans[1];
			addr_wr_r <= hwrite;
			addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= pps_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= {31'h0, hwdata[pps_pkg::CTRL_RUN_BIT]};
		end
	end

	always_comb begin
		rdata_nxt = '0;
		case (haddr[7:0])
			pps_pkg::REG_CTRL: begin
				rdata_nxt = ctrl_r;
			end
			pps_pkg::REG_STATUS: begin
				rdata_nxt = status_word;
			end
			pps_pkg::REG_WORD: begin
				rdata_nxt = {20'h0, host_word};
			end
			default: begin
				rdata_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (rd_sel) begin
			hrdata <= rdata_nxt;
		end
	end
endmodule // pps_scanner

/* sim/pps_scanner_properties.sv */
module pps_checker #(
	parameter int unsigned ONLINE_LEN = 2000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [27:0] test_point_n,
	input wire logic poll_strobe,
	input wire logic adc_start,
	input wire logic online,
	input wire logic [11:0] host_word,
	input wire logic word_select_low,
	input wire logic word_select_high,
	input wire logic [7:0] adc_result,
	input wire logic [2:0] function_sw,
	input wire logic [2:0] range_sw,
	input wire logic [3:0] board_id,
	input wire logic power_sw
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========
	// Cycles since the last poll rise; saturates well past the hold time
	int unsigned since_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) since_r <= 0;
		else if ($rose(poll_strobe)) since_r <= 1;
		else if (since_r != 0 && since_r < 2 * ONLINE_LEN) since_r <= since_r + 1;
	end
	property p_tp_onehot;
		$onehot0(~test_point_n);
	endproperty
	a_tp_onehot: assert property (p_tp_onehot) else $error("two jacks low");
	property p_tp_step;
		$rose(test_point_n[0]) |-> !test_point_n[1];
	endproperty
	a_tp_step: assert property (p_tp_step) else $error("scan skipped a jack");
	property p_freeze;
		poll_strobe && $past(poll_strobe) && $past(poll_strobe, 2) |-> $stable(test_point_n);
	endproperty
	a_freeze: assert property (p_freeze) else $error("scan moved during poll");
	property p_adc_pulse;
		$fell(poll_strobe) |=> adc_start [*8];
	endproperty
	a_adc_pulse: assert property (p_adc_pulse) else $error("no start pulse");
	property p_adc_cause;
		$rose(adc_start) |-> $past(poll_strobe, 2) && !$past(poll_strobe);
	endproperty
	a_adc_cause: assert property (p_adc_cause) else $error("stray start pulse");
	property p_online_hold;
		since_r > 2 && since_r < ONLINE_LEN - 2 |-> online;
	endproperty
	a_online_hold: assert property (p_online_hold) else $error("online dropped");
	property p_online_off;
		since_r > ONLINE_LEN + 4 |-> !online;
	endproperty
	a_online_off: assert property (p_online_off) else $error("online stuck");
	property p_word_ohms;
		word_select_low && !word_select_high |=> host_word == {$past(adc_result), 4'h0};
	endproperty
	a_word_ohms: assert property (p_word_ohms) else $error("bad ohms word");
	property p_word_sw;
		!word_select_low && word_select_high |=>
			host_word == {$past({function_sw, range_sw, board_id, power_sw}), 1'b0};
	endproperty
	a_word_sw: assert property (p_word_sw) else $error("bad switch word");
endmodule // pps_checker

/* sim/pps_host_model.sv */
module pps_host_model #(
	parameter int unsigned POLL_LEN = 120
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [1:0] sel,
	output logic poll_strobe,
	output logic word_select_low,
	output logic word_select_high
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// One strobe per poll; rate is the caller's, so slow hosts can be shown
	int unsigned left_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_r <= 0;
			poll_strobe <= 1'b0;
		end else if (go && left_r == 0) begin
			left_r <= POLL_LEN;
			poll_strobe <= 1'b1;
		end else if (left_r > 1) begin
			left_r <= left_r - 1;
		end else begin
			left_r <= 0;
			poll_strobe <= 1'b0;
		end
	end
	// Word the host sends to the panel; this block only sees the two selects
	localparam logic [3:0] CARD_ID = 4'h6; // Arbitrary card number
	logic [15:0] out_word;
	assign out_word = {8'h00, sel[0], sel[1], 2'b00, CARD_ID};
	assign word_select_low = out_word[7];
	assign word_select_high = out_word[6];
endmodule // pps_host_model

/* sim/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, red_on = 0, blk_on = 0;
	logic red_ground = 0, blk_ground = 0, probes_shorted = 0, power_sw = 0;
	logic [31:0] haddr = 0, hwdata = 0, r1, r2;
	logic [1:0] htrans = 0, sel = 0;
	logic [2:0] hsize = 3'h2, function_sw = 0, range_sw = 0;
	logic [7:0] adc_result = 0;
	logic [3:0] board_id = 0;
	int red_j = 0, blk_j = 0, err_total = 0, num_checks = 0;
	wire hreadyout, hresp, poll_strobe, wsl, wsh, online, adc_start;
	wire [31:0] hrdata;
	wire [27:0] test_point_n;
	wire [11:0] host_word;
	// Probes pick up the pulse of the jack they touch
	wire red_probe_n = !red_on || test_point_n[red_j];
	wire blk_probe_n = !blk_on || test_point_n[blk_j];
	pps_scanner #(.SCAN_DIV(40), .ONLINE_LEN(2000)) DUT (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .test_point_n(test_point_n), .red_probe_n(red_probe_n),
		.blk_probe_n(blk_probe_n), .red_ground(red_ground), .blk_ground(blk_ground),
		.probes_shorted(probes_shorted), .poll_strobe(poll_strobe), .word_select_low(wsl),
		.word_select_high(wsh), .host_word(host_word), .online(online),
		.adc_start(adc_start), .adc_result(adc_result), .function_sw(function_sw),
		.range_sw(range_sw), .board_id(board_id), .power_sw(power_sw));
	pps_host_model #(.POLL_LEN(120)) host (.hclk(hclk), .hresetn(hresetn), .go(go),
		.sel(sel), .poll_strobe(poll_strobe), .word_select_low(wsl), .word_select_high(wsh));
	initial forever #2.5 hclk = ~hclk;
	// ==========
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task poll(input logic [1:0] s, input logic [11:0] e);
		sel <= s;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		repeat (5) @(posedge hclk);
		chk(32'(host_word), 32'(e));
		wait (poll_strobe === 1'b0);
		repeat (3) @(posedge hclk);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge hclk);
		err_total++;
		finish_test;
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({19'h0, online, host_word}, 0);
		{red_on, red_j, blk_on, blk_j} <= {1'b1, 32'd5, 1'b1, 32'd27};
		repeat (1500) @(posedge hclk);
		poll(2'h0, {2'h0, 5'd8, 5'd30});
		ahb(0, 32'h4, 0, r1);
		chk(32'(r1[17:8]), {22'h0, 5'd30, 5'd8});
		red_j <= 0;
		repeat (1500) @(posedge hclk);
		poll(2'h0, {2'h0, 5'd3, 5'd30});
		$display("test probes done");
		red_on <= 1'b0;
		repeat (3500) @(posedge hclk);
		poll(2'h0, {2'h0, 5'd0, 5'd30});
		red_ground <= 1'b1;
		repeat (1500) @(posedge hclk);
		poll(2'h0, {2'h0, 5'd1, 5'd30});
		{red_ground, blk_on, probes_shorted} <= 3'b001;
		repeat (3500) @(posedge hclk);
		poll(2'h0, {2'h0, 5'd2, 5'd2});
		{probes_shorted, blk_ground} <= 2'b01;
		repeat (1500) @(posedge hclk);
		poll(2'h0, {2'h0, 5'd0, 5'd1});
		$display("test special codes done");
		{adc_result, function_sw, range_sw, board_id, power_sw} <= {8'hA5, 3'h5, 3'h3, 5'h19};
		poll(2'h1, 12'hA50);
		poll(2'h2, 12'hAF2);
		poll(2'h3, 12'h000);
		chk(32'(online), 1);
		$display("test mux done");
		sel <= 2'h0;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		ahb(0, 32'h4, 0, r1);
		repeat (90) @(posedge hclk);
		ahb(0, 32'h4, 0, r2);
		chk(32'(r2[4:0]), 32'(r1[4:0]));
		wait (poll_strobe === 1'b0);
		repeat (100) @(posedge hclk);
		ahb(0, 32'h4, 0, r2);
		chk(32'(r2[4:0] != r1[4:0]), 1);
		repeat (2200) @(posedge hclk);
		chk(32'(online), 0);
		$display("test poll done");
		ahb(0, 32'h0, 0, r1);
		chk(r1, 1);
		ahb(0, 32'h10, 0, r1);
		chk(r1, 0);
		ahb(1, 32'h0, 0, r1);
		ahb(0, 32'h4, 0, r1);
		repeat (100) @(posedge hclk);
		ahb(0, 32'h4, 0, r2);
		chk(32'(r2[4:0]), 32'(r1[4:0]));
		ahb(1, 32'h0, 1, r2);
		$display("test registers done");
		finish_test;
	end
endmodule // tb_top

bind pps_scanner pps_checker #(.ONLINE_LEN(ONLINE_LEN)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.test_point_n(test_point_n), .poll_strobe(poll_strobe), .adc_start(adc_start),
	.online(online), .host_word(host_word), .word_select_low(word_select_low),
	.word_select_high(word_select_high), .adc_result(adc_result), .function_sw(function_sw),
	.range_sw(range_sw), .board_id(board_id), .power_sw(power_sw));
